// ### haptic_pkg.sv
// package: register map, field positions, reset values and timing counts
// assumes: shared by the device end, the link monitor and the testbench
package haptic_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [7:0] STATUS_ADDR = 8'h00;
   localparam logic [7:0] MODE_ADDR = 8'h01;
   localparam logic [7:0] LIVE_ADDR = 8'h02;
   localparam logic [7:0] START_ADDR = 8'h0c;
   localparam logic [7:0] FORMAT_ADDR = 8'h1d;
   // mode register fields
   localparam int RESET_BIT = 7;
   localparam int STANDBY_BIT = 6;
   localparam logic [7:0] MODE_RESET_VAL = 8'h40;
   localparam logic [7:0] MODE_WR_MASK = 8'hc7;
   // status register fields
   localparam int OUTCOME_BIT = 3;
   localparam int ID_LSB = 5;
   localparam logic [2:0] ID_VAL = 3'h2; // arbitrary identity value
   // start register field
   localparam int START_BIT = 0;
   // format register fields
   localparam int PWM_ANALOG_BIT = 1;
   localparam int UNSIGNED_BIT = 3;
   localparam int CAP_INPUT_BIT = 5;
   localparam logic [7:0] FORMAT_WR_MASK = 8'h2a;
   localparam logic [7:0] LIVE_RESET_VAL = 8'h00;
   localparam logic [7:0] FORMAT_RESET_VAL = 8'h00;
   // timing: clock 40 MHz, times in ns
   localparam int CLK_NS = 25;
   localparam int RESET_NS = 100;
   localparam int RESET_CYCLES = (RESET_NS + CLK_NS - 1) / CLK_NS;
   localparam int PLAY_CYCLES = 16;
   localparam int TEST_CYCLES = 24;
   // mode selector values
   typedef enum logic [2:0] {
      MODE_INTERNAL = 3'h0,
      MODE_EDGE = 3'h1,
      MODE_LEVEL = 3'h2,
      MODE_STREAM = 3'h3,
      MODE_AUDIO = 3'h4,
      MODE_LIVE = 3'h5,
      MODE_DIAG = 3'h6,
      MODE_CAL = 3'h7
   } mode_sel_t;
endpackage

// ### haptic_link_if.sv
// interface: register strobes and the trigger pin between host and device
// assumes: one clock for both ends, strobes one cycle wide
`timescale 1ns/100ps
`default_nettype none
interface haptic_link_if;
   logic [7:0] addr; // register offset
   logic [7:0] wdata; // write data
   logic wr; // write strobe
   logic rd; // read strobe
   logic [7:0] rdata; // read data
   logic rvalid; // read data valid pulse
   logic input_trigger_pin; // trigger / signal input level
   modport device (input addr, wdata, wr, rd, input_trigger_pin, output rdata, rvalid);
   modport host (output addr, wdata, wr, rd, input_trigger_pin, input rdata, rvalid);
endinterface
`default_nettype wire

// ### trig_edge.sv
// module: rising and falling edge pulses of the trigger pin
// assumes: pin already synchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module trig_edge (
   input wire logic clk_i, // clock
   input wire logic resetn_i, // sync reset, active low
   input wire logic pin_i, // trigger level
   output logic rise_o, // one-cycle rising pulse
   output logic fall_o // one-cycle falling pulse
);
   logic prev_reg;
   logic prev_next;

   // next value of the delayed pin
   always_comb begin
      prev_next = pin_i;
   end

   // register the delayed pin
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
      end
   end

   // edge pulses
   assign rise_o = pin_i & ~prev_reg;
   assign fall_o = ~pin_i & prev_reg;
endmodule
`default_nettype wire

// ### haptic_device.sv
// module: mode control and live playback register logic of the haptic driver
// assumes: host end on haptic_link_if, actuator engines reduced to timers
//
// Functional notes
// - reset bit acts like power cycle
// - full reset aborts playback, restores defaults
// - reset bit self-clears when done
// - standby bit one means standby
// - mode 0: start bit starts playback
// - mode 1: rising edge starts, second cancels
// - mode 2: start bit follows pin
// - mode 3: drive continuously from pin
// - mode 4: audio drive, host sets bits
// - mode 5: drive live value continuously
// - mode 6: diagnostic, clear start, store outcome
// - mode 7: calibration clears start when done
// - every live value write reaches load; the code drives it only in mode 5 outside standby
// - live value signed unless unsigned selected
// - host idles device after live waveform
// - status read clears outcome flag
`timescale 1ns/100ps
`default_nettype none
module haptic_device #(
   parameter int PLAY_LEN = haptic_pkg::PLAY_CYCLES, // triggered waveform length
   parameter int TEST_LEN = haptic_pkg::TEST_CYCLES // diagnostic/calibration length
) (
   input wire logic clk_i, // clock, 40 MHz
   input wire logic resetn_i, // sync reset, active low
   haptic_link_if.device link, // register strobes and trigger pin
   input wire logic test_fail_i, // outcome of the routine at its end
   output logic [7:0] drive_level_o, // signed drive level to the load
   output logic drive_live_o, // drive level is the live register value
   output logic drive_pin_o, // load driven from the pin signal
   output logic pin_analog_o, // pin signal is analog, not pwm
   output logic pin_cap_o, // pin input is ac-coupled
   output logic playing_o, // triggered waveform running
   output logic testing_o, // diagnostic or calibration running
   output logic standby_o // software standby
);
   localparam int CNT_W = 8;

   // elaboration check: the cycle counter is 8 bits wide
   if (PLAY_LEN < 1 || PLAY_LEN > 255 || TEST_LEN < 1 || TEST_LEN > 255) begin : g_len_check
      $error("haptic_device: lengths must be 1..255");
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_RESET = 2'b11
   } eng_state_t;

   // register state
   logic [7:0] mode_reg, mode_next;
   logic [7:0] live_reg, live_next;
   logic [7:0] format_reg, format_next;
   logic start_reg, start_next;
   logic outcome_reg, outcome_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   // engine state
   eng_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   // output state
   logic [7:0] level_reg, level_next;
   logic live_out_reg, live_out_next;
   logic pin_out_reg, pin_out_next;
   logic analog_reg, analog_next;
   logic cap_reg, cap_next;
   logic play_reg, play_next;
   logic test_reg, test_next;
   logic standby_reg, standby_next;

   logic rise, fall;

   trig_edge u_edge (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .pin_i(link.input_trigger_pin),
      .rise_o(rise),
      .fall_o(fall)
   );

   // register read decode
   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] md,
         input logic [7:0] lv, input logic [7:0] fm, input logic st, input logic oc);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         haptic_pkg::STATUS_ADDR: begin
            v[haptic_pkg::ID_LSB +: 3] = haptic_pkg::ID_VAL;
            v[haptic_pkg::OUTCOME_BIT] = oc;
         end
         haptic_pkg::MODE_ADDR: v = md;
         haptic_pkg::LIVE_ADDR: v = lv;
         haptic_pkg::START_ADDR: v[haptic_pkg::START_BIT] = st;
         haptic_pkg::FORMAT_ADDR: v = fm;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // register file, mode engine and drive selection
   always_comb begin
      logic [2:0] sel;
      logic wr_mode, wr_start, stop;
      sel = mode_reg[2:0];
      wr_mode = link.wr && link.addr == haptic_pkg::MODE_ADDR;
      wr_start = link.wr && link.addr == haptic_pkg::START_ADDR;
      stop = 1'b0;
      mode_next = mode_reg;
      live_next = live_reg;
      format_next = format_reg;
      start_next = start_reg;
      outcome_next = outcome_reg;
      state_next = state_reg;
      cnt_next = cnt_reg;
      rvalid_next = link.rd;
      rdata_next = read_mux(link.addr, mode_reg, live_reg, format_reg, start_reg, outcome_reg);
      // status read clears the outcome; a set below wins
      if (link.rd && link.addr == haptic_pkg::STATUS_ADDR) begin
         outcome_next = 1'b0;
      end
      if (state_reg == ST_RESET) begin
         // reset in progress: hold everything at defaults, count down
         if (cnt_reg == '0) begin
            state_next = ST_IDLE;
            mode_next = haptic_pkg::MODE_RESET_VAL;
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end else if (wr_mode && link.wdata[haptic_pkg::RESET_BIT]) begin
         // full reset: abort playback, defaults everywhere
         mode_next = haptic_pkg::MODE_RESET_VAL | 8'h80;
         live_next = haptic_pkg::LIVE_RESET_VAL;
         format_next = haptic_pkg::FORMAT_RESET_VAL;
         start_next = 1'b0;
         outcome_next = 1'b0;
         state_next = ST_RESET;
         cnt_next = CNT_W'(haptic_pkg::RESET_CYCLES - 1);
      end else begin
         if (wr_mode) begin
            mode_next = link.wdata & haptic_pkg::MODE_WR_MASK;
         end
         if (link.wr && link.addr == haptic_pkg::LIVE_ADDR) begin
            live_next = link.wdata;
         end
         if (link.wr && link.addr == haptic_pkg::FORMAT_ADDR) begin
            format_next = link.wdata & haptic_pkg::FORMAT_WR_MASK;
         end
         // starts by software or by the pin, per mode
         case (sel)
            haptic_pkg::MODE_INTERNAL, haptic_pkg::MODE_DIAG, haptic_pkg::MODE_CAL: begin
               if (wr_start && link.wdata[haptic_pkg::START_BIT]) begin
                  start_next = 1'b1;
               end
            end
            haptic_pkg::MODE_EDGE: begin
               if (rise && start_reg) begin
                  stop = 1'b1;
               end else if (rise) begin
                  start_next = 1'b1;
               end
            end
            haptic_pkg::MODE_LEVEL: begin
               if (rise && !start_reg) begin
                  start_next = 1'b1;
               end else if (fall && start_reg) begin
                  stop = 1'b1;
               end
            end
            default: begin
               start_next = start_reg;
            end
         endcase
         if (mode_reg[haptic_pkg::STANDBY_BIT]) begin
            start_next = 1'b0; // standby refuses starts
            stop = start_reg;
         end
         // engine: timed waveform or routine, then start bit clears
         case (state_reg)
            ST_IDLE: begin
               if (start_reg && !stop) begin
                  state_next = ST_RUN;
                  cnt_next = (sel == haptic_pkg::MODE_DIAG || sel == haptic_pkg::MODE_CAL) ?
                     CNT_W'(TEST_LEN - 1) : CNT_W'(PLAY_LEN - 1);
               end
            end
            ST_RUN: begin
               if (stop || wr_mode) begin
                  state_next = ST_IDLE;
                  start_next = 1'b0;
               end else if (cnt_reg == '0) begin
                  state_next = ST_IDLE;
                  start_next = 1'b0;
                  if (sel == haptic_pkg::MODE_DIAG || sel == haptic_pkg::MODE_CAL) begin
                     outcome_next = test_fail_i;
                  end
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
         if (stop) begin
            start_next = 1'b0;
         end
      end
      // drive outputs
      standby_next = mode_next[haptic_pkg::STANDBY_BIT];
      live_out_next = !standby_next && mode_next[2:0] == haptic_pkg::MODE_LIVE;
      pin_out_next = !standby_next && (mode_next[2:0] == haptic_pkg::MODE_STREAM ||
         mode_next[2:0] == haptic_pkg::MODE_AUDIO);
      analog_next = format_next[haptic_pkg::PWM_ANALOG_BIT];
      cap_next = format_next[haptic_pkg::CAP_INPUT_BIT];
      level_next = 8'h00;
      if (live_out_next) begin
         level_next = format_next[haptic_pkg::UNSIGNED_BIT] ? (live_next ^ 8'h80) :
            live_next;
      end
      play_next = state_next == ST_RUN && mode_next[2:0] <= haptic_pkg::MODE_LEVEL;
      test_next = state_next == ST_RUN && mode_next[2:0] >= haptic_pkg::MODE_DIAG;
   end

   // register everything
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode_reg <= haptic_pkg::MODE_RESET_VAL;
         live_reg <= haptic_pkg::LIVE_RESET_VAL;
         format_reg <= haptic_pkg::FORMAT_RESET_VAL;
         start_reg <= 1'b0;
         outcome_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         level_reg <= 8'h00;
         live_out_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         analog_reg <= 1'b0;
         cap_reg <= 1'b0;
         play_reg <= 1'b0;
         test_reg <= 1'b0;
         standby_reg <= 1'b1;
      end else begin
         mode_reg <= mode_next;
         live_reg <= live_next;
         format_reg <= format_next;
         start_reg <= start_next;
         outcome_reg <= outcome_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         level_reg <= level_next;
         live_out_reg <= live_out_next;
         pin_out_reg <= pin_out_next;
         analog_reg <= analog_next;
         cap_reg <= cap_next;
         play_reg <= play_next;
         test_reg <= test_next;
         standby_reg <= standby_next;
      end
   end

   assign link.rdata = rdata_reg;
   assign link.rvalid = rvalid_reg;
   assign drive_level_o = level_reg;
   assign drive_live_o = live_out_reg;
   assign drive_pin_o = pin_out_reg;
   assign pin_analog_o = analog_reg;
   assign pin_cap_o = cap_reg;
   assign playing_o = play_reg;
   assign testing_o = test_reg;
   assign standby_o = standby_reg;
endmodule
`default_nettype wire

// ### haptic_host.sv
// module: host end issuing register writes/reads and driving the trigger pin
// assumes: device end on haptic_link_if answers a read one cycle later
`timescale 1ns/100ps
`default_nettype none
module haptic_host (
   input wire logic clk_i, // clock, 40 MHz
   input wire logic resetn_i, // sync reset, active low
   haptic_link_if.host link, // register strobes and trigger pin
   input wire logic cmd_valid_i, // command request
   input wire logic cmd_write_i, // 1 write, 0 read
   input wire logic [7:0] cmd_addr_i, // register offset
   input wire logic [7:0] cmd_wdata_i, // write data
   input wire logic trig_level_i, // level for the trigger pin
   output logic cmd_ready_o, // command taken this cycle when valid
   output logic rsp_valid_o, // read data pulse
   output logic [7:0] rsp_data_o // read data
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_WAIT = 2'b01,
      H_GAP = 2'b11
   } host_state_t;

   host_state_t state_reg, state_next;
   logic [7:0] addr_reg, addr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic wr_reg, wr_next;
   logic rd_reg, rd_next;
   logic trig_reg, trig_next;
   logic ready_reg, ready_next;
   logic rsp_reg, rsp_next;
   logic [7:0] data_reg, data_next;

   // command sequencing; the host keeps the idle duty, the device ends calibration itself
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      wr_next = 1'b0;
      rd_next = 1'b0;
      trig_next = trig_level_i;
      ready_next = 1'b0;
      rsp_next = 1'b0;
      data_next = data_reg;
      case (state_reg)
         H_IDLE: begin
            if (cmd_valid_i && ready_reg) begin
               addr_next = cmd_addr_i;
               wdata_next = cmd_wdata_i;
               wr_next = cmd_write_i;
               rd_next = !cmd_write_i;
               state_next = cmd_write_i ? H_GAP : H_WAIT;
            end else begin
               ready_next = 1'b1;
            end
         end
         H_WAIT: begin
            if (link.rvalid) begin
               rsp_next = 1'b1;
               data_next = link.rdata;
               state_next = H_GAP;
            end
         end
         H_GAP: begin
            ready_next = 1'b1;
            state_next = H_IDLE;
         end
         default: begin
            state_next = H_IDLE;
         end
      endcase
   end

   // register host state
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_reg <= H_IDLE;
         addr_reg <= 8'h00;
         wdata_reg <= 8'h00;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         trig_reg <= 1'b0;
         ready_reg <= 1'b0;
         rsp_reg <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         trig_reg <= trig_next;
         ready_reg <= ready_next;
         rsp_reg <= rsp_next;
         data_reg <= data_next;
      end
   end

   assign link.addr = addr_reg;
   assign link.wdata = wdata_reg;
   assign link.wr = wr_reg;
   assign link.rd = rd_reg;
   assign link.input_trigger_pin = trig_reg;
   assign cmd_ready_o = ready_reg;
   assign rsp_valid_o = rsp_reg;
   assign rsp_data_o = data_reg;
endmodule
`default_nettype wire

// ### haptic_link_monitor.sv
// checker: relations on the register link between the host and device ends
// assumes: one clock; the bench instantiates it beside the link interface
`timescale 1ns/100ps
`default_nettype none
module haptic_link_monitor (
   input wire logic clk_i, // clock
   input wire logic resetn_i, // sync reset, active low
   input wire logic [7:0] addr, // register offset
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic rvalid, // read data pulse
   input wire logic input_trigger_pin // trigger pin, not checked here
);
   logic [7:0] age_reg, age_next; // cycles since a software reset write
   logic [7:0] live_reg, live_next; // expected live register content
   logic rst_wr;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // track software resets and the live register, writes in reset skipped
   always_comb begin
      rst_wr = wr && addr == haptic_pkg::MODE_ADDR && wdata[7] && age_reg > 8'h05;
      age_next = (age_reg == 8'hff) ? age_reg : age_reg + 8'h01;
      live_next = live_reg;
      if (!resetn_i || rst_wr) begin
         age_next = resetn_i ? 8'h00 : 8'hff;
         live_next = 8'h00;
      end else if (wr && addr == haptic_pkg::LIVE_ADDR && age_reg > 8'h05) begin
         live_next = wdata;
      end
   end
   // register the tracking state
   always_ff @(posedge clk_i) begin
      age_reg <= age_next;
      live_reg <= live_next;
   end
   // a read strobe at one offset
   sequence s_rd(logic [7:0] a);
      rd && addr == a;
   endsequence
   chk_read_answer: assert property (rd |=> rvalid)
      else $error("read not answered in the next cycle");
   chk_rvalid_cause: assert property (rvalid |-> $past(rd))
      else $error("read data without a read");
   chk_strobe_single: assert property ((wr || rd) |=> !(wr || rd))
      else $error("strobe wider than one cycle");
   chk_unmapped_zero: assert property (rd && !(addr inside {8'h00, 8'h01, 8'h02, 8'h0c,
      8'h1d}) |=> rdata == 8'h00) else $error("unmapped read not zero");
   chk_status_fields: assert property (s_rd(haptic_pkg::STATUS_ADDR) |=>
      rdata[7:5] == haptic_pkg::ID_VAL && rdata[4] == 1'b0 && rdata[2:0] == 3'h0)
      else $error("status fixed fields wrong");
   chk_mode_reserved: assert property (s_rd(haptic_pkg::MODE_ADDR) |=> rdata[5:3] == 3'h0)
      else $error("mode reserved bits not zero");
   chk_reset_busy: assert property (s_rd(haptic_pkg::MODE_ADDR) and age_reg <= 8'h01
      |=> rdata == 8'hc0) else $error("mode not at reset state during software reset");
   chk_reset_done: assert property (s_rd(haptic_pkg::MODE_ADDR) and age_reg >= 8'h08
      |=> !rdata[7]) else $error("reset bit did not clear");
   chk_live_readback: assert property (s_rd(haptic_pkg::LIVE_ADDR) and age_reg > 8'h05
      |=> rdata == live_reg) else $error("live register readback wrong");
   chk_format_mask: assert property (s_rd(haptic_pkg::FORMAT_ADDR)
      |=> (rdata & ~haptic_pkg::FORMAT_WR_MASK) == 8'h00) else $error("format bits wrong");
endmodule
`default_nettype wire

// ### test_haptic_mode_control_rtp.sv
// testbench: host and device ends joined by the link, checked against a model
// assumes: package, link interface, both ends and the link monitor compiled before
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module test_haptic_mode_control_rtp;
   localparam int PLAY = 12;
   localparam int TLEN = 10;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, trig = 1'b0, test_fail = 1'b0;
   logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00;
   logic cmd_ready, rsp_valid, drive_live, drive_pin, pin_analog, pin_cap;
   logic playing, testing, standby;
   logic [7:0] rsp_data, drive_level, q;
   logic [31:0] seed = 32'd5503;
   int n_fail = 0, n_compared = 0;
   int mode_m = 8'h40, live_m = 0, fmt_m = 0, outc_m = 0; // model registers
   int e_lvl; // expected drive level, popped once per compare
   int wq[$]; // live values written
   haptic_link_if link();
   haptic_device #(.PLAY_LEN(PLAY), .TEST_LEN(TLEN)) u_haptic_device (.clk_i(clk_i),
      .resetn_i(resetn_i), .link(link), .test_fail_i(test_fail), .drive_level_o(drive_level),
      .drive_live_o(drive_live), .drive_pin_o(drive_pin), .pin_analog_o(pin_analog),
      .pin_cap_o(pin_cap), .playing_o(playing), .testing_o(testing), .standby_o(standby));
   haptic_host u_haptic_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
      .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
      .cmd_wdata_i(cmd_wdata), .trig_level_i(trig), .cmd_ready_o(cmd_ready),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
   haptic_link_monitor mon (.clk_i(clk_i), .resetn_i(resetn_i), .addr(link.addr),
      .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
      .rvalid(link.rvalid), .input_trigger_pin(link.input_trigger_pin));
   // clock, 25 ns period
   always begin
      #12.5 clk_i = ~clk_i;
   end
   // next pseudo-random word
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // one host command, held until taken; read data lands in q
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(negedge clk_i);
      while (cmd_ready !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      while (!w && rsp_valid !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      q = rsp_data;
      if (n >= 20) begin
         n_fail++;
         $display("Error at %0t: host command stalled", $time);
      end
   endtask
   // write through the host and update the model
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
      if (a == haptic_pkg::MODE_ADDR && d[7]) begin
         mode_m = 8'h40;
         live_m = 0;
         fmt_m = 0;
         outc_m = 0;
      end else if (a == haptic_pkg::MODE_ADDR) begin
         mode_m = d & haptic_pkg::MODE_WR_MASK;
      end else if (a == haptic_pkg::LIVE_ADDR) begin
         live_m = d;
      end else if (a == haptic_pkg::FORMAT_ADDR) begin
         fmt_m = d & haptic_pkg::FORMAT_WR_MASK;
      end
   endtask
   // read and compare with the model; a status read clears the outcome
   task automatic rd_chk(input logic [7:0] a);
      int e;
      e = 0;
      case (a)
         haptic_pkg::STATUS_ADDR: e = (haptic_pkg::ID_VAL << 5) | (outc_m << 3);
         haptic_pkg::MODE_ADDR: e = mode_m;
         haptic_pkg::LIVE_ADDR: e = live_m;
         haptic_pkg::FORMAT_ADDR: e = fmt_m;
         default: e = 0;
      endcase
      xfer(1'b0, a, 8'h00);
      `CHECK(q, e)
      if (a == haptic_pkg::STATUS_ADDR) outc_m = 0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic pin(input logic v);
      @(posedge clk_i);
      trig <= v;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      #100000;
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd_chk(8'h00);
      rd_chk(8'h01);
      rd_chk(8'h02);
      rd_chk(8'h1d);
      rd_chk(8'h55);
      `CHECK(standby, 1'b1)
      $display("test reset values done");
      wr_reg(haptic_pkg::MODE_ADDR, 8'h3d);
      settle(3);
      `CHECK(drive_live, 1'b1)
      `CHECK(standby, 1'b0)
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         wr_reg(haptic_pkg::FORMAT_ADDR, seed[7:0] ^ {4'h0, i[0], 3'h0});
         wr_reg(haptic_pkg::LIVE_ADDR, seed[15:8]);
         wq.push_back(live_m);
         settle(3);
         e_lvl = wq.pop_front() ^ ((fmt_m & 8'h08) << 4);
         `CHECK(drive_level, e_lvl)
         `CHECK(pin_analog, fmt_m[1])
         `CHECK(pin_cap, fmt_m[5])
         rd_chk(haptic_pkg::LIVE_ADDR);
         rd_chk(haptic_pkg::FORMAT_ADDR);
      end
      wr_reg(haptic_pkg::MODE_ADDR, 8'h45);
      settle(3);
      `CHECK(drive_live, 1'b0)
      `CHECK(standby, 1'b1)
      for (int m = 3; m < 5; m++) begin
         wr_reg(haptic_pkg::MODE_ADDR, 8'(m));
         settle(3);
         `CHECK(drive_pin, 1'b1)
      end
      $display("test live playback and drive modes done");
      wr_reg(haptic_pkg::MODE_ADDR, 8'h00);
      wr_reg(haptic_pkg::START_ADDR, 8'h01);
      xfer(1'b0, haptic_pkg::START_ADDR, 8'h00);
      `CHECK(q[0], 1'b1)
      `CHECK(playing, 1'b1)
      `CHECK(drive_pin, 1'b0)
      settle(PLAY + 6);
      `CHECK(playing, 1'b0)
      xfer(1'b0, haptic_pkg::START_ADDR, 8'h00);
      `CHECK(q[0], 1'b0)
      wr_reg(haptic_pkg::MODE_ADDR, 8'h01);
      pin(1'b1);
      settle(5);
      `CHECK(playing, 1'b1)
      pin(1'b0);
      settle(2);
      pin(1'b1);
      settle(5);
      `CHECK(playing, 1'b0)
      pin(1'b0);
      wr_reg(haptic_pkg::MODE_ADDR, 8'h02);
      pin(1'b1);
      settle(5);
      `CHECK(playing, 1'b1)
      pin(1'b0);
      settle(5);
      `CHECK(playing, 1'b0)
      $display("test triggered modes done");
      for (int m = 6; m < 8; m++) begin
         @(posedge clk_i);
         test_fail <= (m == 6);
         wr_reg(haptic_pkg::MODE_ADDR, 8'(m));
         wr_reg(haptic_pkg::START_ADDR, 8'h01);
         settle(4);
         `CHECK(testing, 1'b1)
         q = 8'h01;
         for (int n = 0; n < 10 && q[0] === 1'b1; n++) xfer(1'b0, haptic_pkg::START_ADDR, 8'h00);
         `CHECK(q[0], 1'b0)
         outc_m = (m == 6);
         rd_chk(haptic_pkg::STATUS_ADDR);
         rd_chk(haptic_pkg::STATUS_ADDR);
         `CHECK(testing, 1'b0)
      end
      $display("test diagnostic and calibration done");
      wr_reg(haptic_pkg::MODE_ADDR, 8'h00);
      wr_reg(haptic_pkg::LIVE_ADDR, 8'h5a);
      wr_reg(haptic_pkg::START_ADDR, 8'h01);
      settle(4);
      `CHECK(playing, 1'b1)
      wr_reg(haptic_pkg::MODE_ADDR, 8'h80);
      xfer(1'b0, haptic_pkg::MODE_ADDR, 8'h00);
      `CHECK(q, 8'hc0)
      `CHECK(playing, 1'b0)
      settle(10);
      rd_chk(haptic_pkg::MODE_ADDR);
      rd_chk(haptic_pkg::LIVE_ADDR);
      `CHECK(standby, 1'b1)
      $display("test full reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
